// ---- hdl/rcu_top.sv ----
// Reading conditioning unit top: register port, filter, relative, rate.
// Assumes converter strobes one raw conversion per conv_valid cycle.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rcu_top
	import rcu_pkg::*;
#(
	parameter int RANGE_MAX = 6,
	parameter logic [RAW_W-1:0] FULL_SCALE = 24'h01D4C0,
	parameter int AVERAGING_ON_INDICATOR_DEPTH = 100,
	parameter int PLC_TENTH_CYC = TENTH_PLC_CYC,
	parameter int GATE_CYCLES = GATE_CYC,
	parameter int SHOW_CYCLES = SHOW_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	// Converter
	input wire logic conv_valid,
	input wire logic signed [RAW_W-1:0] conv_raw,
	// Conditioned reading
	output logic rdg_valid,
	output rcu_pkg::rcu_reading_t rdg,
	// Converter setup
	output logic [RANGE_W-1:0] range_sel,
	output logic [COUNT_W-1:0] line_cycle_count,
	output logic [31:0] integ_cycles,
	output rcu_pkg::rcu_band_t ac_band,
	// Display
	output logic range_show,
	output logic averaging_on_indicator,
	output logic auto_range_indicator,
	output logic relative_indicator
);
	import rcu_pkg::*;
	if (AVERAGING_ON_INDICATOR_DEPTH < int'(COUNT_MAX) || SHOW_CYCLES < 1) begin : g_chk
		$error("rcu_top: filter depth or show time too small");
	end

	////////////////////////////////////////////////////////////////////////
	// Register port

	rcu_ctrl_t ctrl;
	logic [COUNT_W-1:0] fcount;
	logic key_up;
	logic key_dn;
	logic key_auto;
	logic key_rel;
	logic force_auto;
	logic wr_ctrl;
	logic wr_count;
	logic wr_key;
	rcu_ctrl_t wctrl;
	assign wr_ctrl = bus_wr && bus_addr == REG_CTRL;
	assign wr_count = bus_wr && bus_addr == REG_COUNT;
	assign wr_key = bus_wr && bus_addr == REG_KEY;
	assign wctrl = rcu_ctrl_t'(bus_wdata[7:0]);

	// Illegal function or rate codes are dropped so decode never sees them
	always_ff @(posedge clk) begin
		if (!rst_b) ctrl <= rcu_ctrl_t'(CTRL_RST);
		else if (wr_ctrl && bus_wdata[3:0] <= 4'h9 && bus_wdata[7:6] != 2'h3) ctrl <= wctrl;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) fcount <= COUNT_RST;
		else if (wr_count && bus_wdata[6:0] != 7'h00 && bus_wdata[6:0] <= COUNT_MAX
			&& bus_wdata[31:7] == 25'h0)
			fcount <= bus_wdata[6:0];
	end

	always_ff @(posedge clk) begin
		key_up <= rst_b && wr_key && bus_wdata[KEY_UP];
		key_dn <= rst_b && wr_key && bus_wdata[KEY_DN];
		key_auto <= rst_b && wr_key && bus_wdata[KEY_AUTO];
		key_rel <= rst_b && wr_key && bus_wdata[KEY_REL];
		force_auto <= rst_b && bus_wr && bus_addr == REG_RESET && bus_wdata[0];
	end

	////////////////////////////////////////////////////////////////////////
	// Ranging

	logic auto_ok;
	logic auto_on;
	logic [RANGE_W-1:0] range;
	assign auto_ok = !(ctrl.func inside {fn_cont, fn_diode});

	rcu_range #(
		.RANGE_MAX(RANGE_MAX),
		.FULL_SCALE(FULL_SCALE)
	) u_range (
		.clk(clk),
		.rst_b(rst_b),
		.force_auto(force_auto),
		.key_up(key_up),
		.key_dn(key_dn),
		.key_auto(key_auto),
		.auto_ok(auto_ok),
		.conv_valid(conv_valid),
		.conv_mag(rcu_mag(conv_raw)),
		.range(range),
		.auto_on(auto_on)
	);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			range_sel <= RANGE_RST;
			auto_range_indicator <= 1'b1;
		end else begin
			range_sel <= range;
			auto_range_indicator <= auto_on;
		end
	end

	// Range flash; readings are held back while it shows
	logic [31:0] show_cnt;
	always_ff @(posedge clk) begin
		if (!rst_b) show_cnt <= 32'h0;
		else if (range != range_sel && !auto_on) show_cnt <= 32'(SHOW_CYCLES);
		else if (show_cnt != 32'h0) show_cnt <= show_cnt - 32'h1;
	end
	always_ff @(posedge clk) begin
		range_show <= rst_b && (show_cnt > 32'h1 || (range != range_sel && !auto_on));
	end

	////////////////////////////////////////////////////////////////////////
	// Averaging

	logic bypass;
	logic [COUNT_W-1:0] eff_count;
	logic [RANGE_W+COUNT_W+5:0] cfg;
	logic [RANGE_W+COUNT_W+5:0] cfg_q;
	logic clear;
	logic mean_valid;
	logic signed [RAW_W-1:0] mean_data;
	// A count of one passes raw conversions through the same path
	assign bypass = !ctrl.averaging_on_indicator_on || rcu_fn_fixed(ctrl.func);
	assign eff_count = bypass ? 7'h01 : fcount;
	assign cfg = {ctrl.func, ctrl.sliding_mean_mode, bypass, eff_count, range};
	assign clear = !rst_b || cfg != cfg_q;

	always_ff @(posedge clk) begin
		cfg_q <= cfg;
	end

	rcu_mean #(
		.DEPTH(AVERAGING_ON_INDICATOR_DEPTH),
		.RAW_W(RAW_W)
	) u_mean (
		.clk(clk),
		.rst_b(rst_b),
		.clear(clear),
		.sliding(ctrl.sliding_mean_mode),
		.count(eff_count),
		.in_valid(conv_valid),
		.in_data(conv_raw),
		.out_valid(mean_valid),
		.out_data(mean_data)
	);

	always_ff @(posedge clk) begin
		averaging_on_indicator <= rst_b && ctrl.averaging_on_indicator_on;
	end

	////////////////////////////////////////////////////////////////////////
	// Overflow and relative

	logic ovr;
	always_ff @(posedge clk) begin
		if (!rst_b) ovr <= 1'b0;
		else if (conv_valid) ovr <= (rcu_mag(conv_raw) >= FULL_SCALE);
	end

	logic [9:0] rel_on;
	logic signed [VAL_W-1:0] rel_off [10];
	logic signed [VAL_W-1:0] common;
	logic signed [VAL_W-1:0] last_common;
	logic [RANGE_W-1:0] mean_range;
	// Scale by the conversion's own range; auto ranging moves range before the mean
	always_ff @(posedge clk) begin
		if (!rst_b) mean_range <= RANGE_RST;
		else if (conv_valid) mean_range <= range;
	end
	// Offsets kept in lowest-range units so every range shares them
	assign common = VAL_W'(mean_data) * rcu_pow10(mean_range);

	always_ff @(posedge clk) begin
		if (!rst_b) last_common <= '0;
		else if (mean_valid) last_common <= common;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) rel_on <= 10'h000;
		else if (key_rel) rel_on[ctrl.func] <= !rel_on[ctrl.func];
	end
	always_ff @(posedge clk) begin
		if (key_rel && !rel_on[ctrl.func]) rel_off[ctrl.func] <= last_common;
	end
	always_ff @(posedge clk) begin
		relative_indicator <= rst_b && rel_on[ctrl.func];
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdg_valid <= 1'b0;
			rdg <= '0;
		end else begin
			rdg_valid <= mean_valid && !range_show;
			if (mean_valid) begin
				rdg.range_exceeded_message <= ovr;
				rdg.value <= rel_on[ctrl.func] ? common - rel_off[ctrl.func] : common;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Rate and bandwidth

	rcu_rate_t eff_rate;
	logic [COUNT_W-1:0] next_lcc;
	always_comb begin
		eff_rate = ctrl.rate;
		if (ctrl.func == fn_cont) eff_rate = rate_fast;
		if (ctrl.func == fn_diode) eff_rate = rate_med;
		unique case (eff_rate)
			rate_fast: next_lcc = LCC_FAST;
			rate_slow: next_lcc = LCC_SLOW;
			default: next_lcc = LCC_MED;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			line_cycle_count <= LCC_MED;
			integ_cycles <= 32'(PLC_TENTH_CYC) * 32'(LCC_MED);
			ac_band <= band_none;
		end else begin
			line_cycle_count <= next_lcc;
			if (ctrl.func inside {fn_freq, fn_per}) integ_cycles <= 32'(GATE_CYCLES);
			else integ_cycles <= 32'(PLC_TENTH_CYC) * 32'(next_lcc);
			if (!(ctrl.func inside {fn_acv, fn_aci})) ac_band <= band_none;
			else if (eff_rate == rate_fast) ac_band <= band_500hz;
			else if (eff_rate == rate_slow) ac_band <= band_5hz;
			else ac_band <= band_50hz;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port

	always_ff @(posedge clk) begin
		if (!rst_b || !bus_rd) bus_rdata <= 32'h0;
		else begin
			unique case (bus_addr)
				REG_CTRL: bus_rdata <= {24'h0, ctrl};
				REG_COUNT: bus_rdata <= {25'h0, fcount};
				REG_STATUS: bus_rdata <= {24'h0, rdg.range_exceeded_message, range_show,
					rel_on[ctrl.func], ctrl.averaging_on_indicator_on, auto_on, range};
				REG_RDG_LO: bus_rdata <= rdg.value[31:0];
				REG_RDG_HI: bus_rdata <= 32'(rdg.value[VAL_W-1:32]);
				default: bus_rdata <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	property p_remote_auto;
		@(posedge clk) disable iff (!rst_b)
		bus_wr && bus_addr == REG_RESET && bus_wdata[0] |-> ##3 auto_range_indicator;
	endproperty
	a_remote_auto: assert property (p_remote_auto) else $error("auto not restored");

	property p_manual_step;
		@(posedge clk) disable iff (!rst_b)
		key_up && !auto_on && int'(range) < RANGE_MAX |=> range == $past(range) + RANGE_ONE;
	endproperty
	a_manual_step: assert property (p_manual_step) else $error("manual step lost");

	property p_auto_up;
		@(posedge clk) disable iff (!rst_b)
		auto_on && auto_ok && conv_valid && rcu_mag(conv_raw) >= FULL_SCALE
			&& int'(range) < RANGE_MAX && !key_up && !key_dn && !key_auto |=> range > $past(range);
	endproperty
	a_auto_up: assert property (p_auto_up) else $error("no up-range at full scale");

	property p_auto_cancel;
		@(posedge clk) disable iff (!rst_b)
		key_auto && auto_on && auto_ok && !force_auto |=> !auto_on && $stable(range);
	endproperty
	a_auto_cancel: assert property (p_auto_cancel) else $error("range moved on cancel");

	property p_auto_key_ignored;
		@(posedge clk) disable iff (!rst_b)
		key_auto && !auto_ok && !force_auto && !key_up && !key_dn |=> $stable(auto_on);
	endproperty
	a_auto_key_ignored: assert property (p_auto_key_ignored) else $error("auto key acted");

	property p_bypass_pass;
		@(posedge clk) disable iff (!rst_b)
		conv_valid && bypass && !clear |=> mean_valid && mean_data == $past(conv_raw);
	endproperty
	a_bypass_pass: assert property (p_bypass_pass) else $error("bypass altered data");

	property p_rel_on;
		@(posedge clk) disable iff (!rst_b)
		key_rel && !rel_on[ctrl.func] && !wr_ctrl ##1 !wr_ctrl |=> relative_indicator;
	endproperty
	a_rel_on: assert property (p_rel_on) else $error("relative did not light");

	property p_rate_fast;
		@(posedge clk) disable iff (!rst_b)
		ctrl.rate == rate_fast && !rcu_fn_fixed(ctrl.func) |=> line_cycle_count == LCC_FAST
			&& integ_cycles == 32'(PLC_TENTH_CYC);
	endproperty
	a_rate_fast: assert property (p_rate_fast) else $error("fast rate wrong");

	property p_gate;
		@(posedge clk) disable iff (!rst_b)
		ctrl.func == fn_per |=> integ_cycles == 32'(GATE_CYCLES);
	endproperty
	a_gate: assert property (p_gate) else $error("gate time wrong");

	property p_ovr_raw;
		@(posedge clk) disable iff (!rst_b)
		conv_valid && rcu_mag(conv_raw) < FULL_SCALE |=> !ovr;
	endproperty
	a_ovr_raw: assert property (p_ovr_raw) else $error("overflow without raw excess");

	property p_averaging_on_indicator_ind;
		@(posedge clk) disable iff (!rst_b)
		$rose(ctrl.averaging_on_indicator_on) ##1 ctrl.averaging_on_indicator_on |-> averaging_on_indicator [*2];
	endproperty
	a_averaging_on_indicator_ind: assert property (p_averaging_on_indicator_ind) else $error("filter indicator dark");

	c_auto_up: cover property (@(posedge clk) disable iff (!rst_b) auto_on ##1 $changed(range));
	c_rel: cover property (@(posedge clk) disable iff (!rst_b) $rose(relative_indicator));
	c_repeat: cover property (@(posedge clk) disable iff (!rst_b)
		!ctrl.sliding_mean_mode && !bypass && rdg_valid);
	c_show: cover property (@(posedge clk) disable iff (!rst_b) $fell(range_show));
endmodule : rcu_top
`default_nettype wire

// ---- inc/rcu_pkg.sv ----
// Reading conditioning unit: constants, types and register map.
// Assumes one 50 MHz clock and a converter delivering signed counts.
// Functional notes
// - Power-up and remote reset select automatic ranging.
// - Manual keys leave auto without stepping; in manual they step one range and show the new range briefly.
// - Auto ranging steps up at full scale, down below one tenth.
// - Cancelling auto with its key keeps the present range.
// - Auto key does nothing for continuity and diode test.
// - Filtered reading is the mean of 1 to 100 conversions.
// - No averaging for frequency, period, continuity or diode.
// - Sliding mode emits a mean per conversion once the stack fills.
// - Repeat mode emits one mean per full stack, then refills.
// - Relative on captures the reading; later readings subtract it.
// - One offset per function, used unchanged on every range.
// - Overflow judged on raw input; offset neither hides nor widens it.
// - Relative key toggles capture-and-light and off.
// - Rate fast, medium, slow give 0.1, 1, 10 line cycles.
// - One line cycle is 20 ms at 50 Hz.
// - AC functions take bandwidth from the rate setting.
// - Fixed rates: continuity fast, diode medium, freq and period 1 s.
// - Averaging indicator follows the filter switch.
`default_nettype none
package rcu_pkg;
	localparam int RAW_W = 24;
	localparam int VAL_W = 48;
	localparam int RANGE_W = 3;
	localparam int COUNT_W = 7;
	localparam logic [COUNT_W-1:0] COUNT_MAX = 7'h64;
	localparam logic [COUNT_W-1:0] COUNT_RST = 7'h0A;
	localparam logic [RANGE_W-1:0] RANGE_RST = 3'h0;
	localparam logic [RANGE_W-1:0] RANGE_ONE = 3'h1;
	localparam logic [COUNT_W-1:0] LCC_FAST = 7'h01;
	localparam logic [COUNT_W-1:0] LCC_MED = 7'h0A;
	localparam logic [COUNT_W-1:0] LCC_SLOW = 7'h64;
	localparam int CLK_HZ = 50_000_000;
	localparam int PLC_MS = 20;
	localparam int GATE_MS = 1000;
	localparam int SHOW_MS = 500;
	localparam int TENTH_PLC_CYC = CLK_HZ / 1000 * PLC_MS / 10;
	localparam int GATE_CYC = CLK_HZ / 1000 * GATE_MS;
	localparam int SHOW_CYC = CLK_HZ / 1000 * SHOW_MS;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COUNT = 8'h04;
	localparam logic [7:0] REG_KEY = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDG_LO = 8'h10;
	localparam logic [7:0] REG_RDG_HI = 8'h14;
	localparam logic [7:0] REG_RESET = 8'h18;
	localparam int KEY_UP = 0;
	localparam int KEY_DN = 1;
	localparam int KEY_AUTO = 2;
	localparam int KEY_REL = 3;
	localparam logic [7:0] CTRL_RST = 8'h60;
	typedef enum logic [3:0] {fn_dcv, fn_acv, fn_dci, fn_aci, fn_res2, fn_res4,
		fn_freq, fn_per, fn_cont, fn_diode} rcu_func_t;
	typedef enum logic [1:0] {rate_fast, rate_med, rate_slow} rcu_rate_t;
	typedef enum logic [1:0] {band_none, band_500hz, band_50hz, band_5hz} rcu_band_t;
	typedef struct packed {
		rcu_rate_t rate;
		logic sliding_mean_mode;
		logic averaging_on_indicator_on;
		rcu_func_t func;
	} rcu_ctrl_t;
	typedef struct packed {
		logic range_exceeded_message;
		logic signed [VAL_W-1:0] value;
	} rcu_reading_t;
	function automatic logic rcu_fn_fixed(input rcu_func_t f);
		return f inside {fn_freq, fn_per, fn_cont, fn_diode};
	endfunction : rcu_fn_fixed
	function automatic logic [RAW_W-1:0] rcu_mag(input logic signed [RAW_W-1:0] v);
		return v[RAW_W-1] ? -v : v;
	endfunction : rcu_mag
	function automatic logic signed [VAL_W-1:0] rcu_pow10(input logic [RANGE_W-1:0] r);
		logic signed [VAL_W-1:0] v;
		v = 48'sh1;
		for (int i = 0; i < 7; i++) begin
			if (i < int'(r)) v = v * 48'shA;
		end
		return v;
	endfunction : rcu_pow10
endpackage : rcu_pkg
`default_nettype wire

// ---- hdl/rcu_mean.sv ----
// Averaging stack: sliding or repeating mean over a programmable count.
// Assumes count stays constant between clears.
`timescale 1ns/10ps
`default_nettype none
module rcu_mean #(
	parameter int DEPTH = 100,
	parameter int RAW_W = 24
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic clear,
	input wire logic sliding,
	input wire logic [6:0] count,
	// Conversions in, means out
	input wire logic in_valid,
	input wire logic signed [RAW_W-1:0] in_data,
	output logic out_valid,
	output logic signed [RAW_W-1:0] out_data
);
	localparam int SUM_W = RAW_W + 8;
	if (DEPTH < 1 || DEPTH > 127) begin : g_chk
		$error("rcu_mean: DEPTH must be 1 to 127");
	end
	logic signed [RAW_W-1:0] stack [DEPTH];
	logic [6:0] ptr;
	logic [6:0] fill;
	logic signed [SUM_W-1:0] sum;
	logic signed [SUM_W-1:0] next_sum;
	logic full;
	logic last;
	always_comb begin
		full = (fill == count);
		next_sum = sum + SUM_W'(in_data);
		if (full) next_sum = next_sum - SUM_W'(stack[ptr]);
		last = full || (fill + 7'h01 == count);
	end
	always_ff @(posedge clk) begin
		if (!rst_b || clear) begin
			sum <= '0;
			fill <= 7'h00;
			ptr <= 7'h00;
		end else if (in_valid) begin
			if (!sliding && last) begin
				sum <= '0;
				fill <= 7'h00;
				ptr <= 7'h00;
			end else begin
				sum <= next_sum;
				if (!full) fill <= fill + 7'h01;
				ptr <= (ptr + 7'h01 == count) ? 7'h00 : ptr + 7'h01;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (in_valid) stack[ptr] <= in_data;
	end
	// Divider kept combinational: one mean per conversion at most
	always_ff @(posedge clk) begin
		out_valid <= rst_b && !clear && in_valid && last;
		out_data <= RAW_W'(next_sum / $signed({1'b0, count}));
	end
endmodule : rcu_mean
`default_nettype wire

// ---- hdl/rcu_range.sv ----
// Range selector: manual stepping and automatic up and down ranging.
// Assumes key strobes are one cycle long.
`timescale 1ns/10ps
`default_nettype none
module rcu_range
	import rcu_pkg::*;
#(
	parameter int RANGE_MAX = 6,
	parameter logic [RAW_W-1:0] FULL_SCALE = 24'h01D4C0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic force_auto,
	// Keys
	input wire logic key_up,
	input wire logic key_dn,
	input wire logic key_auto,
	input wire logic auto_ok,
	// Raw magnitude
	input wire logic conv_valid,
	input wire logic [RAW_W-1:0] conv_mag,
	// State
	output logic [RANGE_W-1:0] range,
	output logic auto_on
);
	if (RANGE_MAX < 1 || RANGE_MAX >= 2 ** RANGE_W) begin : g_chk
		$error("rcu_range: RANGE_MAX out of reach");
	end
	logic top;
	logic ranging;
	assign top = (int'(range) >= RANGE_MAX);
	// A cancel that meets a conversion wins, so the range stays put
	assign ranging = auto_on && auto_ok && conv_valid && !key_auto;
	always_ff @(posedge clk) begin
		if (!rst_b || force_auto) auto_on <= 1'b1;
		else if (key_auto && auto_ok) auto_on <= !auto_on;
		else if (key_up || key_dn) auto_on <= 1'b0;
	end
	always_ff @(posedge clk) begin
		if (!rst_b) range <= RANGE_RST;
		else if (!auto_on && key_up && !top) range <= range + RANGE_ONE;
		else if (!auto_on && key_dn && range != RANGE_RST) range <= range - RANGE_ONE;
		else if (ranging && conv_mag >= FULL_SCALE && !top) range <= range + RANGE_ONE;
		else if (ranging && conv_mag < FULL_SCALE / 10 && range != RANGE_RST)
			range <= range - RANGE_ONE;
	end
endmodule : rcu_range
`default_nettype wire

// ---- verif/rcu_conv_model.sv ----
// Converter front end model: one raw conversion per bench request.
// Assumes the bench pulses go for one cycle with the raw value beside it.
`timescale 1ns/10ps
`default_nettype none
module rcu_conv_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Request from bench
	input wire logic go,
	input wire logic signed [rcu_pkg::RAW_W-1:0] value,
	// Converter outputs
	output logic conv_valid,
	output logic signed [rcu_pkg::RAW_W-1:0] conv_raw
);
	import rcu_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	// Data toggles between conversions so a stale capture shows up
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			conv_valid <= 1'b0;
			conv_raw <= '0;
		end else begin
			conv_valid <= go;
			conv_raw <= go ? value : ~conv_raw;
		end
	end
endmodule : rcu_conv_model
`default_nettype wire

// ---- verif/tb.sv ----
// Testbench for the reading conditioning unit.
// Assumes the shortened show, line cycle and gate counts set below.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import rcu_pkg::*;
	logic clk, rst_b, bus_wr, bus_rd, go, conv_valid, rdg_valid, range_show;
	logic averaging_on_indicator, auto_range_indicator, relative_indicator;
	logic [7:0] bus_addr;
	logic [31:0] bus_wdata, bus_rdata, integ_cycles, d;
	logic signed [RAW_W-1:0] value, conv_raw;
	rcu_reading_t rdg;
	logic [RANGE_W-1:0] range_sel;
	logic [COUNT_W-1:0] line_cycle_count;
	rcu_band_t ac_band;
	int error_cnt, checks, nval, n0;
	////////////////////////////////////////////////////////////////////////////////
	rcu_top #(.PLC_TENTH_CYC(10), .GATE_CYCLES(50), .SHOW_CYCLES(4)) i_dut (
		.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.conv_valid(conv_valid), .conv_raw(conv_raw), .rdg_valid(rdg_valid), .rdg(rdg),
		.range_sel(range_sel), .line_cycle_count(line_cycle_count),
		.integ_cycles(integ_cycles), .ac_band(ac_band), .range_show(range_show),
		.averaging_on_indicator(averaging_on_indicator),
		.auto_range_indicator(auto_range_indicator),
		.relative_indicator(relative_indicator));
	rcu_conv_model i_conv (.clk(clk), .rst_b(rst_b), .go(go), .value(value),
		.conv_valid(conv_valid), .conv_raw(conv_raw));
	always #10 clk = ~clk;
	always @(posedge clk) if (rdg_valid === 1'b1) nval <= nval + 1;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= v;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask : rd
	task automatic settle();
		repeat (7) @(posedge clk);
		#1;
	endtask : settle
	task automatic cfg(input rcu_func_t f, input logic fl, sl, input logic [1:0] r);
		wr(REG_CTRL, {24'h000000, r, sl, fl, f});
		settle();
	endtask : cfg
	task automatic conv(input logic signed [RAW_W-1:0] v);
		@(posedge clk);
		go <= 1'b1;
		value <= v;
		@(posedge clk);
		go <= 1'b0;
	endtask : conv
	task automatic key(input int k);
		wr(REG_KEY, 32'h1 << k);
		settle();
	endtask : key
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("auto ind", 48'h1, auto_range_indicator);
		chk("lcc", 48'h0A, line_cycle_count);
		chk("integ", 48'h64, integ_cycles);
		chk("band", 48'h0, ac_band);
		rd(REG_STATUS);
		chk("status", 48'h08, d);
		rd(8'h20);
		chk("unmapped", 48'h0, d);
		$display("test reset done");
	endtask : t_reset
	task automatic t_rate();
		logic [6:0] l;
		for (int r = 0; r < 3; r++) begin
			l = (r == 0) ? 7'h01 : (r == 1) ? 7'h0A : 7'h64;
			cfg(fn_acv, 1'b0, 1'b1, 2'(r));
			chk("lcc", 48'(l), line_cycle_count);
			chk("integ", 48'(l) * 48'h0A, integ_cycles);
			chk("band", 48'(r + 1), ac_band);
		end
		cfg(fn_aci, 1'b0, 1'b1, 2'h2);
		chk("aci band", 48'h3, ac_band);
		cfg(fn_freq, 1'b0, 1'b1, 2'h2);
		chk("gate", 48'h32, integ_cycles);
		cfg(fn_per, 1'b0, 1'b1, 2'h0);
		chk("per gate", 48'h32, integ_cycles);
		cfg(fn_cont, 1'b0, 1'b1, 2'h2);
		chk("cont lcc", 48'h01, line_cycle_count);
		cfg(fn_diode, 1'b0, 1'b1, 2'h2);
		chk("diode lcc", 48'h0A, line_cycle_count);
		$display("test rate done");
	endtask : t_rate
	task automatic t_filter();
		cfg(fn_dcv, 1'b0, 1'b1, 2'h1);
		conv(24'h00C350);
		settle();
		chk("bypass", 48'h00C350, rdg.value);
		wr(REG_COUNT, 32'h4);
		cfg(fn_dcv, 1'b1, 1'b0, 2'h1);
		chk("averaging_on_indicator ind", 48'h1, averaging_on_indicator);
		n0 = nval;
		for (int i = 0; i < 8; i++) conv((i % 4 == 3) ? 24'h9000 : 24'h4000 + 24'(i % 4) * 24'h1000);
		settle();
		chk("repeat n", 48'h2, 48'(nval - n0));
		chk("repeat mean", 48'h6000, rdg.value);
		cfg(fn_dcv, 1'b1, 1'b1, 2'h1);
		n0 = nval;
		for (int i = 0; i < 4; i++) conv((i == 3) ? 24'h9000 : 24'h4000 + 24'(i) * 24'h1000);
		conv(24'h00D000);
		settle();
		chk("slide n", 48'h2, 48'(nval - n0));
		chk("slide mean", 48'h8400, rdg.value);
		cfg(fn_freq, 1'b1, 1'b1, 2'h1);
		n0 = nval;
		conv(24'h001234);
		conv(24'h004321);
		settle();
		chk("freq n", 48'h2, 48'(nval - n0));
		chk("freq val", 48'h4321, rdg.value);
		cfg(fn_dcv, 1'b0, 1'b1, 2'h1);
		chk("averaging_on_indicator off", 48'h0, averaging_on_indicator);
		$display("test filter done");
	endtask : t_filter
	task automatic t_rel();
		conv(24'h007530);
		settle();
		key(KEY_REL);
		chk("rel ind", 48'h1, relative_indicator);
		conv(24'h004E20);
		settle();
		chk("rel val", -48'sh2710, rdg.value);
		cfg(fn_acv, 1'b0, 1'b1, 2'h1);
		chk("rel other fn", 48'h0, relative_indicator);
		cfg(fn_dcv, 1'b0, 1'b1, 2'h1);
		key(KEY_REL);
		chk("rel off", 48'h0, relative_indicator);
		conv(24'h004E20);
		settle();
		chk("plain val", 48'h4E20, rdg.value);
		$display("test relative done");
	endtask : t_rel
	task automatic t_range();
		key(KEY_UP);
		chk("auto off", 48'h0, auto_range_indicator);
		wr(REG_KEY, 32'h1 << KEY_UP);
		repeat (3) @(posedge clk);
		#1 chk("show", 48'h1, range_show);
		settle();
		chk("up one", 48'h1, range_sel);
		key(KEY_DN);
		chk("down one", 48'h0, range_sel);
		key(KEY_AUTO);
		chk("auto on", 48'h1, auto_range_indicator);
		conv(24'h01FBD0);
		settle();
		chk("overflow", 48'h1, rdg.range_exceeded_message);
		chk("upranged", 48'h1, range_sel);
		chk("up value", 48'h01FBD0, rdg.value);
		conv(24'h001388);
		settle();
		chk("downranged", 48'h0, range_sel);
		conv(24'h01D4C0);
		settle();
		key(KEY_AUTO);
		chk("keep range", 48'h1, range_sel);
		cfg(fn_cont, 1'b0, 1'b1, 2'h1);
		key(KEY_AUTO);
		chk("cont auto", 48'h0, auto_range_indicator);
		cfg(fn_dcv, 1'b0, 1'b1, 2'h1);
		wr(REG_RESET, 32'h1);
		settle();
		chk("remote reset", 48'h1, auto_range_indicator);
		$display("test range done");
	endtask : t_range
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		#100000;
		error_cnt++;
		complete_run();
	end
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		{bus_wr, bus_rd, go} = 3'h0;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		value = '0;
		error_cnt = 0;
		checks = 0;
		nval = 0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		#1 t_reset();
		t_rate();
		t_filter();
		t_rel();
		t_range();
		complete_run();
	end
endmodule : tb
`default_nettype wire
